// ### rtl/aotf_map.svh
// register offsets, field positions, reset values and pattern constants
// assumes inclusion by bare name from the package and the design files
`ifndef AOTF_MAP_SVH
`define AOTF_MAP_SVH

`define AOTF_OFF_TPS 8'h0d
`define AOTF_OFF_STC 8'h0e
`define AOTF_OFF_TRIM 8'h10
`define AOTF_OFF_OFC 8'h14

`define AOTF_RST_TPS 8'h00
`define AOTF_RST_STC 8'h00
`define AOTF_RST_TRIM 8'h00
`define AOTF_RST_OFC 8'h05

`define AOTF_SEL_HI 3
`define AOTF_SEL_LO 0
`define AOTF_POL_BIT 2
`define AOTF_FMT_HI 1
`define AOTF_FMT_LO 0

`define AOTF_SEL_OFF 4'h0
`define AOTF_SEL_MID 4'h1
`define AOTF_SEL_PFS 4'h2
`define AOTF_SEL_NFS 4'h3
`define AOTF_SEL_CHK 4'h4
`define AOTF_SEL_PNL 4'h5
`define AOTF_SEL_PNS 4'h6
`define AOTF_SEL_TOG 4'h7
`define AOTF_SEL_USR 4'h8
`define AOTF_SEL_RMP 4'hf

`define AOTF_FMT_OFFBIN 2'h0
`define AOTF_FMT_TWOS 2'h1
`define AOTF_FMT_GRAY 2'h2

`define AOTF_WORD_MID 11'h400
`define AOTF_WORD_PFS 11'h7ff
`define AOTF_WORD_NFS 11'h000
`define AOTF_WORD_CHK0 11'h555
`define AOTF_WORD_CHK1 11'h2aa
`define AOTF_PNL_SEED 23'h7fffff
`define AOTF_PNS_SEED 9'h1ff

`define AOTF_FIFO_DEPTH 4

`endif

// ### rtl/aotf_pkg.sv
// types shared by the output test and format logic and its bench
// assumes aotf_map.svh on the include path
`include "aotf_map.svh"

package aotf_pkg;

  // one channel's register copy
  typedef struct packed {
    logic [7:0] tps;
    logic [7:0] stc;
    logic [7:0] trim;
    logic [7:0] ofc;
  } aotf_cfg_t;

  // one channel's pattern generator state
  typedef struct packed {
    logic [22:0] lp;
    logic [8:0] sp;
    logic [10:0] ramp;
    logic tog;
  } aotf_gen_t;

  // one word for each channel, channel a in the low half
  typedef struct packed {
    logic [10:0] b;
    logic [10:0] a;
  } aotf_pair_t;

endpackage

// ### rtl/aotf_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock; depth is a power of two
`timescale 1ns/10ps
`default_nettype none

module aotf_fifo #(
  parameter int W = 22,
  parameter int D = 4
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL = (AW+1)'(D);

  logic [W-1:0] mem_q [D];
  logic [W-1:0] mem_d [D];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];

  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d = wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // flags are flops so both ready and valid leave straight from a register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < D; i++) begin
        mem_q[i] <= '0;
      end
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      mem_q <= mem_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      in_ready <= (cnt_d != FULL);
      out_valid <= (cnt_d != '0);
    end
  end

  a_hold_stall: assert property (@(posedge clock) disable iff (!rstn) // (R11)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("fifo output changed while stalled");
  a_no_overflow: assert property (@(posedge clock) disable iff (!rstn)
    cnt_q == FULL |-> !in_ready)
    else $error("fifo ready while full");
  c_fifo_full: cover property (@(posedge clock) disable iff (!rstn)
    cnt_q == FULL);

endmodule

`default_nettype wire

// ### rtl/aotf_top.sv
// per-channel test pattern, polarity and number format for two channels
// assumes samples and register writes arrive on the same clock
// Notes on behaviour
// (R01) selector 0 samples; 1 midscale, 2 positive, 3 negative full scale
// (R02) selector 4 emits an alternating checkerboard word
// (R03) selector 7 alternates all ones and all zeros per sample
// (R04) selector 5 emits the long pseudorandom sequence
// (R05) selector 6 emits the short pseudorandom sequence
// (R06) selector 8 emits the user test word
// (R07) selector 15 emits an incrementing ramp; 9 to 14 must not be written
// (R08) polarity bit set passes data, cleared inverts every bit; reset is set
// (R09) format 00 offset binary, 01 twos complement (reset), 10 gray; not 11
// (R10) each channel keeps its own selector, polarity and format copy
// (R11) each word is formed whole from one settings snapshot, none partial
`timescale 1ns/10ps
`default_nettype none
`include "aotf_map.svh"

module aotf_top (
  input wire logic clock,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic [1:0] reg_chan,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  input wire logic in_valid,
  output logic in_ready,
  input wire aotf_pkg::aotf_pair_t in_sample,
  input wire aotf_pkg::aotf_pair_t user_word,
  output logic out_valid,
  input wire logic out_ready,
  output aotf_pkg::aotf_pair_t out_data
);

  aotf_pkg::aotf_cfg_t cfg_q [2];
  aotf_pkg::aotf_cfg_t cfg_d [2];
  aotf_pkg::aotf_gen_t gen_q [2];
  aotf_pkg::aotf_gen_t gen_d [2];
  logic [7:0] rdata_d;
  logic [10:0] word [2];
  logic [10:0] smp [2];
  logic [10:0] usr [2];
  aotf_pkg::aotf_pair_t push_data;
  logic push;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  assign smp[0] = in_sample.a;
  assign smp[1] = in_sample.b;
  assign usr[0] = user_word.a;
  assign usr[1] = user_word.b;
  assign push = in_valid && in_ready;

  // raw word for the selected source, always in offset binary
  function automatic logic [10:0] pick_word(input logic [3:0] sel,
      input logic [10:0] s, input logic [10:0] u,
      input aotf_pkg::aotf_gen_t g);
    logic [10:0] r;
    r = s;
    case (sel)
      `AOTF_SEL_OFF: r = s; // (R01)
      `AOTF_SEL_MID: r = `AOTF_WORD_MID; // (R01)
      `AOTF_SEL_PFS: r = `AOTF_WORD_PFS; // (R01)
      `AOTF_SEL_NFS: r = `AOTF_WORD_NFS; // (R01)
      `AOTF_SEL_CHK: r = g.tog ? `AOTF_WORD_CHK1 : `AOTF_WORD_CHK0; // (R02)
      `AOTF_SEL_PNL: r = g.lp[10:0]; // (R04)
      `AOTF_SEL_PNS: r = {g.sp[1:0], g.sp}; // (R05)
      `AOTF_SEL_TOG: r = {11{g.tog}}; // (R03)
      `AOTF_SEL_USR: r = u; // (R06)
      `AOTF_SEL_RMP: r = g.ramp; // (R07)
      // unused codes fall back to samples rather than freezing the bus
      default: r = s;
    endcase
    return r;
  endfunction

  function automatic logic [10:0] fmt_word(input logic [10:0] w,
      input logic [7:0] ofc);
    logic [10:0] r;
    r = w;
    case (ofc[`AOTF_FMT_HI:`AOTF_FMT_LO])
      `AOTF_FMT_OFFBIN: r = w; // (R09)
      `AOTF_FMT_TWOS: r = {~w[10], w[9:0]}; // (R09)
      `AOTF_FMT_GRAY: r = w ^ {1'b0, w[10:1]}; // (R09)
      default: r = w;
    endcase
    if (!ofc[`AOTF_POL_BIT]) begin
      r = ~r; // (R08)
    end
    return r;
  endfunction

  // register file, one copy per channel, written by channel mask
  always_comb begin
    cfg_d = cfg_q;
    for (int c = 0; c < 2; c++) begin
      if (reg_wr && reg_chan[c]) begin // (R10)
        case (reg_addr)
          `AOTF_OFF_TPS: cfg_d[c].tps = reg_wdata;
          `AOTF_OFF_STC: cfg_d[c].stc = reg_wdata;
          `AOTF_OFF_TRIM: cfg_d[c].trim = reg_wdata;
          `AOTF_OFF_OFC: cfg_d[c].ofc = reg_wdata;
          default: cfg_d[c] = cfg_q[c];
        endcase
      end
    end
  end

  // reads show channel a unless only channel b is selected
  always_comb begin
    aotf_pkg::aotf_cfg_t rc;
    rc = (reg_chan == 2'h2) ? cfg_q[1] : cfg_q[0];
    case (reg_addr)
      `AOTF_OFF_TPS: rdata_d = rc.tps;
      `AOTF_OFF_STC: rdata_d = rc.stc;
      `AOTF_OFF_TRIM: rdata_d = rc.trim;
      `AOTF_OFF_OFC: rdata_d = rc.ofc;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int c = 0; c < 2; c++) begin
        cfg_q[c].tps <= `AOTF_RST_TPS;
        cfg_q[c].stc <= `AOTF_RST_STC;
        cfg_q[c].trim <= `AOTF_RST_TRIM;
        cfg_q[c].ofc <= `AOTF_RST_OFC; // (R08)
      end
      reg_rdata_q <= 8'h00;
    end else begin
      cfg_q <= cfg_d;
      reg_rdata_q <= rdata_d;
    end
  end

  // word formation is combinational on the settings of this cycle, so a
  // register write lands between two words and never splits one
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      word[c] = fmt_word(pick_word(cfg_q[c].tps[`AOTF_SEL_HI:`AOTF_SEL_LO],
        smp[c], usr[c], gen_q[c]), cfg_q[c].ofc); // (R11)
    end
    push_data.a = word[0];
    push_data.b = word[1];
  end

  // generators step only on accepted words so back-pressure keeps sequences
  always_comb begin
    gen_d = gen_q;
    for (int c = 0; c < 2; c++) begin
      if (push) begin
        gen_d[c].lp = {gen_q[c].lp[21:0],
          gen_q[c].lp[22] ^ gen_q[c].lp[17]}; // (R04)
        gen_d[c].sp = {gen_q[c].sp[7:0],
          gen_q[c].sp[8] ^ gen_q[c].sp[4]}; // (R05)
        gen_d[c].ramp = gen_q[c].ramp + 11'h001; // (R07)
        gen_d[c].tog = ~gen_q[c].tog; // (R03)
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int c = 0; c < 2; c++) begin
        gen_q[c].lp <= `AOTF_PNL_SEED;
        gen_q[c].sp <= `AOTF_PNS_SEED;
        gen_q[c].ramp <= 11'h000;
        gen_q[c].tog <= 1'b0;
      end
    end else begin
      gen_q <= gen_d;
    end
  end

  aotf_fifo #(
    .W(22),
    .D(`AOTF_FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rstn(rstn),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(push_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

  logic [3:0] sel_a;
  logic [1:0] fmt_a;
  logic pol_a;
  logic plain_a;
  assign sel_a = cfg_q[0].tps[`AOTF_SEL_HI:`AOTF_SEL_LO];
  assign fmt_a = cfg_q[0].ofc[`AOTF_FMT_HI:`AOTF_FMT_LO];
  assign pol_a = cfg_q[0].ofc[`AOTF_POL_BIT];
  assign plain_a = (fmt_a == 2'h0) && pol_a;

  a_fixed_words: assert property (push && plain_a && // (R01)
    sel_a inside {4'h1, 4'h2, 4'h3} |-> word[0] ==
    (sel_a == 4'h1 ? 11'h400 : sel_a == 4'h2 ? 11'h7ff : 11'h000))
    else $error("fixed test word wrong");
  a_check_alt: assert property (push && sel_a == 4'h4 && plain_a ##1 // (R02)
    push && sel_a == 4'h4 && $stable(cfg_q[0].ofc) |->
    word[0] == ~$past(word[0]) && (word[0] == 11'h555 ||
    word[0] == 11'h2aa))
    else $error("checkerboard not alternating");
  a_toggle_word: assert property (push && sel_a == 4'h7 && plain_a ##1 // (R03)
    push && sel_a == 4'h7 && $stable(cfg_q[0].ofc) |->
    word[0] == ~$past(word[0]) && (word[0] == 11'h000 ||
    word[0] == 11'h7ff))
    else $error("toggle word not alternating");
  a_long_seq: assert property (push && sel_a == 4'h5 && plain_a ##1 // (R04)
    push && sel_a == 4'h5 && $stable(cfg_q[0].ofc) |->
    word[0][10:1] == $past(word[0][9:0]))
    else $error("long sequence did not shift");
  a_short_seq: assert property (push && sel_a == 4'h6 && plain_a ##1 // (R05)
    push && sel_a == 4'h6 && $stable(cfg_q[0].ofc) |->
    word[0][8:1] == $past(word[0][7:0]))
    else $error("short sequence did not shift");
  a_user_word: assert property (push && sel_a == 4'h8 && plain_a |-> // (R06)
    word[0] == user_word.a)
    else $error("user word not emitted");
  a_ramp_step: assert property (push && sel_a == 4'hf |=> // (R07)
    gen_q[0].ramp == $past(gen_q[0].ramp) + 11'h001)
    else $error("ramp did not step");
  a_pol_invert: assert property (push && sel_a == 4'h0 && // (R08)
    fmt_a == 2'h0 && !pol_a |-> word[0] == ~in_sample.a)
    else $error("inversion wrong");
  a_twos_gray: assert property (push && sel_a == 4'h0 && pol_a && // (R09)
    fmt_a inside {2'h1, 2'h2} |-> word[0] == (fmt_a == 2'h1 ?
    {~in_sample.a[10], in_sample.a[9:0]} :
    in_sample.a ^ {1'b0, in_sample.a[10:1]}))
    else $error("number format wrong");
  a_chan_indep: assert property (reg_wr && reg_chan == 2'h1 |=> // (R10)
    cfg_q[1] == $past(cfg_q[1]))
    else $error("channel b changed by channel a write");
  a_word_whole: assert property (push && $past(push) && // (R11)
    $stable(cfg_q[0]) && sel_a == 4'h1 |-> $stable(word[0]))
    else $error("word changed without a settings change");

  c_ramp_run: cover property (push && sel_a == 4'hf ##1 push [*3]);
  c_gray_out: cover property (push && fmt_a == 2'h2 && sel_a == 4'h0);
  c_stall: cover property (in_valid && !in_ready);

endmodule

`default_nettype wire

// ### dv/aotf_sink.sv
// downstream capture model standing on the formatted output stream
// assumes the block's clock; hold stops taking, slow takes at random
`timescale 1ns/10ps
`default_nettype none

module aotf_sink (
  input wire logic clock,
  input wire logic rstn,
  input wire logic hold,
  input wire logic slow,
  output logic ready
);
  logic [7:0] r_q;
  // ready moves just after the edge so the block never sees it mid-cycle
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      r_q <= 8'h5a;
      ready <= 1'b0;
    end else begin
      r_q <= {r_q[6:0], r_q[7] ^ r_q[5] ^ r_q[4] ^ r_q[3]};
      ready <= #1 !hold && (!slow || r_q[0]);
    end
  end
endmodule

`default_nettype wire

// ### dv/tb_top.sv
// self-checking bench for the output test and format block
// assumes aotf_top, aotf_fifo and the sink model are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "aotf_map.svh"

module tb_top;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr = 1'b0;
  logic [1:0] reg_chan = 2'h1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata_q;
  logic in_valid = 1'b0;
  logic in_ready, out_valid, out_ready;
  logic hold = 1'b0;
  logic slow = 1'b0;
  aotf_pkg::aotf_pair_t in_sample = '0, user_word = '0, out_data;
  int error_cnt = 0;
  int cmp_count = 0;
  int acc_cnt = 0;
  logic [15:0] rnd = 16'h0050;
  logic [7:0] tps_m [2];
  logic [7:0] ofc_m [2];
  logic [22:0] lp [2];
  logic [8:0] sp [2];
  logic [10:0] rmp [2];
  logic tg [2];
  logic [21:0] exq [$];
  logic [3:0] sels [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
    4'h7, 4'h8, 4'hf};

  always #4 clock = ~clock;

  aotf_top uut (.clock, .rstn, .reg_wr, .reg_chan, .reg_addr, .reg_wdata,
    .reg_rdata_q, .in_valid, .in_ready, .in_sample, .user_word,
    .out_valid, .out_ready, .out_data);
  aotf_sink snk (.clock, .rstn, .hold, .slow, .ready(out_ready));

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // raw pattern first, then number format, then polarity
  function automatic logic [10:0] form(input int c, input logic [10:0] s,
      input logic [10:0] u);
    logic [10:0] w;
    case (tps_m[c][3:0])
      4'h1: w = 11'h400;
      4'h2: w = 11'h7ff;
      4'h3: w = 11'h000;
      4'h4: w = tg[c] ? 11'h2aa : 11'h555;
      4'h5: w = lp[c][10:0];
      4'h6: w = {sp[c][1:0], sp[c]};
      4'h7: w = {11{tg[c]}};
      4'h8: w = u;
      4'hf: w = rmp[c];
      default: w = s;
    endcase
    case (ofc_m[c][1:0])
      2'h1: w[10] = ~w[10];
      2'h2: w = w ^ (w >> 1);
      default: ;
    endcase
    return ofc_m[c][2] ? w : ~w;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [1:0] ch, input logic [7:0] a,
      input logic [7:0] d);
    @(posedge clock);
    #1 reg_wr = 1'b1;
    reg_chan = ch;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock);
    #1 reg_wr = 1'b0;
    for (int c = 0; c < 2; c++) begin
      if (ch[c] && a == `AOTF_OFF_TPS) tps_m[c] = d;
      if (ch[c] && a == `AOTF_OFF_OFC) ofc_m[c] = d;
    end
  endtask

  task automatic rd(input logic [1:0] ch, input logic [7:0] a,
      output logic [7:0] d);
    @(posedge clock);
    #1 reg_chan = ch;
    reg_addr = a;
    @(posedge clock);
    #1 d = reg_rdata_q;
  endtask

  task automatic send(input int n);
    for (int k = 0; k < n; k++) begin
      rnd = lfsr(rnd);
      in_sample = {rnd[10:0], rnd[15:5]};
      rnd = lfsr(rnd);
      user_word = {rnd[15:5], rnd[10:0]};
      in_valid = 1'b1;
      do @(posedge clock); while (!in_ready);
      #1;
    end
    in_valid = 1'b0;
  endtask

  // pop before push: a word taken at this edge cannot leave at it
  always @(posedge clock) begin
    logic [21:0] e;
    if (out_valid && out_ready) begin
      chk(exq.size() != 0, 1'b1);
      if (exq.size() != 0) begin
        e = exq.pop_front();
        chk(out_data.a, e[10:0]);
        chk(out_data.b, e[21:11]);
      end
    end
    if (rstn && in_valid && in_ready) begin
      acc_cnt++;
      exq.push_back({form(1, in_sample.b, user_word.b),
        form(0, in_sample.a, user_word.a)});
      for (int c = 0; c < 2; c++) begin
        lp[c] = {lp[c][21:0], lp[c][22] ^ lp[c][17]};
        sp[c] = {sp[c][7:0], sp[c][8] ^ sp[c][4]};
        rmp[c] = rmp[c] + 11'h001;
        tg[c] = ~tg[c];
      end
    end
  end

  initial begin
    #400000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    logic [7:0] v;
    for (int c = 0; c < 2; c++) begin
      tps_m[c] = 8'h00;
      ofc_m[c] = 8'h05;
      lp[c] = 23'h7fffff;
      sp[c] = 9'h1ff;
      rmp[c] = 11'h000;
      tg[c] = 1'b0;
    end
    repeat (6) @(posedge clock);
    #1 rstn = 1'b1;
    for (int c = 0; c < 2; c++) begin
      rd(2'(c + 1), `AOTF_OFF_TPS, v);
      chk(v, 8'h00);
      rd(2'(c + 1), `AOTF_OFF_OFC, v);
      chk(v, 8'h05);
      rd(2'(c + 1), 8'h0f, v);
      chk(v, 8'h00);
    end
    // mask 0 must leave both copies alone
    wr(2'h3, `AOTF_OFF_TRIM, 8'h3c);
    wr(2'h1, `AOTF_OFF_TRIM, 8'hc3);
    wr(2'h0, `AOTF_OFF_TRIM, 8'h99);
    rd(2'h1, `AOTF_OFF_TRIM, v);
    chk(v, 8'hc3);
    rd(2'h2, `AOTF_OFF_TRIM, v);
    chk(v, 8'h3c);
    for (int i = 0; i < 10; i++) begin
      for (int f = 0; f < 3; f++) begin
        for (int p = 0; p < 2; p++) begin
          rnd = lfsr(rnd);
          wr(2'h1, `AOTF_OFF_TPS, {rnd[7:4], sels[i]});
          wr(2'h2, `AOTF_OFF_TPS, {rnd[11:8], sels[(i + 3) % 10]});
          wr(2'h1, `AOTF_OFF_OFC, {5'h00, p[0], f[1:0]});
          wr(2'h2, `AOTF_OFF_OFC, {5'h00, ~p[0], 2'((f + 1) % 3)});
          slow = rnd[0];
          send(5);
        end
      end
    end
    // fill against a stalled sink, then drain
    slow = 1'b0;
    repeat (20) @(posedge clock);
    #1 hold = 1'b1;
    repeat (3) @(posedge clock);
    #1 acc_cnt = 0;
    in_valid = 1'b1;
    repeat (8) @(posedge clock);
    #1 chk(acc_cnt, `AOTF_FIFO_DEPTH);
    chk(in_ready, 1'b0);
    in_valid = 1'b0;
    hold = 1'b0;
    repeat (12) @(posedge clock);
    #1 chk(exq.size(), 0);
    chk(out_valid, 1'b0);
    give_verdict();
  end
endmodule

`default_nettype wire
